//--- test/pspc_ctrl_model.sv
// memory controller model driving the pin side of the sram block
`timescale 1ns/1ps
module pspc_ctrl_model (
  input wire logic clk,
  output logic clock_qualify_n,
  output logic [2:0] sel,
  output logic writeRequest_n,
  output logic advance_or_load,
  output logic [3:0] lane_write_select_n,
  output logic [3:0] addrIn,
  output logic [35:0] wbus
);
  logic active;
  logic burstWr;
  logic pendWr;
  logic [35:0] pendD;

  initial begin
    clock_qualify_n = 1'b1;
    sel = 3'h6;
    writeRequest_n = 1'b1;
    advance_or_load = 1'b0;
    lane_write_select_n = 4'hf;
    addrIn = 4'h0;
    wbus = 36'h0;
    active = 1'b0;
    burstWr = 1'b0;
    pendWr = 1'b0;
    pendD = 36'h0;
  end

  // ------------------------------------------------------------------
  // one bus beat, stretched by st unqualified cycles
  // ------------------------------------------------------------------
  task automatic beat(input logic [2:0] s, input logic w, input logic adv,
      input logic [3:0] ln, input logic [3:0] a, input logic [35:0] d, input int st);
    for (int i = 0; i <= st; i++) begin
      @(posedge clk);
      clock_qualify_n <= (i < st);
      sel <= s;
      writeRequest_n <= w;
      advance_or_load <= adv;
      lane_write_select_n <= ln;
      addrIn <= a;
      wbus <= pendWr ? pendD : ~wbus; // released bus keeps moving
    end
    if (!adv) begin
      active = (s == 3'h2);
      burstWr = !w;
    end
    pendWr = active && burstWr;
    pendD = d;
  endtask
endmodule

//--- test/tb_pspc_sram_pins.sv
// self-checking bench for the pipelined sram pin control block
`timescale 1ns/1ps
module tb_pspc_sram_pins;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic oeN = 1'b0;
  logic strap = 1'b1;
  logic capReady = 1'b1;
  logic qN, weN, adv, dOe, pOe, capValid, lastQual;
  logic [2:0] sel;
  logic [3:0] ln, addr, pOut;
  logic [35:0] wbus;
  logic [35:0] held;
  logic [31:0] dOut, r, cm;
  logic [43:0] ce;
  pspc_pkg::pspc_capture_s capData;
  logic [35:0] mem [16];
  logic [35:0] rdQ [$];
  logic [43:0] capQ [$];
  int mismatches = 0;
  int checked = 0;
  int seed = 32'h9e5a9f3b;

  always #10 clk = ~clk;

  pspc_ctrl_model ctrl (.clk(clk), .clock_qualify_n(qN), .sel(sel), .writeRequest_n(weN),
    .advance_or_load(adv), .lane_write_select_n(ln), .addrIn(addr), .wbus(wbus));
  pspc_sram_pins dut (.clk(clk), .rst(rst), .clock_qualify_n(qN), .select_low_a_n(sel[2]),
    .select_high(sel[1]), .select_low_b_n(sel[0]), .writeRequest_n(weN),
    .advance_or_load(adv), .lane_write_select_n(ln), .addrIn(addr),
    .outputEnable_n(oeN), .burstModeStrap(strap), .dataIn(wbus[31:0]), .dataOut(dOut),
    .dataOe(dOe), .parity_lines_in(wbus[35:32]), .parity_lines_out(pOut),
    .parityOe(pOe), .captureValid(capValid), .captureReady(capReady),
    .captureData(capData));

  // ------------------------------------------------------------------
  // compare and closing tasks
  // ------------------------------------------------------------------
  task automatic cmpRd(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpCap(input logic [43:0] got, input logic [43:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // stimulus tasks
  // ------------------------------------------------------------------
  function automatic logic [35:0] rnd();
    return 36'({$random(seed), $random(seed)});
  endfunction

  task automatic wr(input logic [3:0] a, input logic [3:0] lnN, input logic [35:0] d,
      input int st, input logic ad = 1'b0);
    ctrl.beat(3'h2, 1'b0, ad, lnN, a, d, st);
    for (int i = 0; i < 4; i++) begin
      if (!lnN[i]) begin
        mem[a][i*8+:8] = d[i*8+:8];
        mem[a][32+i] = d[32+i];
      end
    end
    capQ.push_back({a, ~lnN, d[35:32] & ~lnN, d[31:0]});
  endtask

  task automatic rd(input logic [3:0] a, input int st, input logic ad = 1'b0);
    ctrl.beat(3'h2, 1'b1, ad, 4'hf, a, 36'h0, st);
    if (oeN === 1'b0) rdQ.push_back(mem[a]);
  endtask

  task automatic idle(input int n);
    repeat (n) ctrl.beat(3'h6, 1'b1, 1'b0, 4'hf, 4'h0, 36'h0, 0);
  endtask

  task automatic burst(input logic w, input logic [3:0] b);
    logic [1:0] o;
    for (int k = 0; k < 4; k++) begin
      o = strap ? (b[1:0] ^ k[1:0]) : (b[1:0] + k[1:0]);
      if (w) wr({b[3:2], o}, 4'h0, rnd(), 0, k != 0);
      else rd({b[3:2], o}, 0, k != 0);
    end
  endtask

  task automatic reset_dut(input logic m);
    @(posedge clk);
    rst <= 1'b1;
    strap <= m;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    idle(6);
  endtask

  // ------------------------------------------------------------------
  // monitors
  // ------------------------------------------------------------------
  always @(posedge clk) lastQual <= !rst && !qN;

  always @(negedge clk) begin
    if (!rst && lastQual === 1'b1 && dOe === 1'b1) begin
      if (rdQ.size() == 0) cmpRd({pOut, dOut}, 36'hx);
      else cmpRd({pOut, dOut}, rdQ.pop_front());
      cmpRd({35'h0, pOe}, {35'h0, dOe});
    end
    if (!rst && lastQual === 1'b0) cmpRd({pOut, dOut}, held);
    if (oeN === 1'b1) cmpRd({34'h0, pOe, dOe}, 36'h0);
    held = {pOut, dOut};
  end

  always @(posedge clk) begin
    if (!rst && capValid === 1'b1 && capReady === 1'b1) begin
      ce = (capQ.size() != 0) ? capQ.pop_front() : 44'hx;
      cm = {{8{ce[39]}}, {8{ce[38]}}, {8{ce[37]}}, {8{ce[36]}}};
      cmpCap({capData.addr, capData.laneWrite, capData.parity & ce[39:36], capData.data & cm},
        {ce[43:40], ce[39:36], ce[35:32], ce[31:0] & cm});
    end
  end

  initial begin
    #1000000;
    mismatches++;
    close_out();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    reset_dut(1'b1);
    for (int a = 0; a < 16; a++) wr(a[3:0], 4'h0, rnd(), 0);
    for (int n = 0; n < 200; n++) begin
      r = $random(seed);
      capReady <= r[9] | r[10];
      if (r[0]) wr(r[7:4], (r[15:12] == 4'hf) ? 4'h7 : r[15:12], rnd(),
        (r[3:2] == 2'h0) ? int'(r[17:16]) : 0);
      else rd(r[7:4], (r[3:2] == 2'h0) ? int'(r[17:16]) : 0);
    end
    capReady <= 1'b1;
    idle(3);
    for (int s = 0; s < 8; s++) begin
      if (s == 2) rd(4'h3, 0);
      else begin
        ctrl.beat(s[2:0], 1'b1, 1'b0, 4'hf, 4'h3, 36'h0, 0);
        ctrl.beat(3'h2, 1'b1, 1'b1, 4'hf, 4'h3, 36'h0, 0);
      end
    end
    idle(3);
    oeN <= 1'b1;
    rd(4'h5, 0);
    idle(3);
    oeN <= 1'b0;
    for (int m = 1; m >= 0; m--) begin
      if (m == 0) reset_dut(1'b0);
      for (int b = 0; b < 4; b++) begin
        burst(1'b1, 4'(b * 5));
        burst(1'b0, 4'(b * 5));
      end
      idle(3);
    end
    capReady <= 1'b0;
    for (int a = 0; a < 32; a++) wr(a[3:0], 4'h0, rnd(), 0);
    idle(3);
    repeat (100) begin
      @(posedge clk);
      capReady <= $random(seed);
    end
    capReady <= 1'b1;
    repeat (40) @(posedge clk);
    cmpCap(44'(capQ.size()), 44'h0);
    cmpRd(36'(rdQ.size()), 36'h0);
    close_out();
  end
endmodule

//--- verilog/pspc_fifo.sv
// fifo with registered head for the captured write stream
`timescale 1ns/1ps
module pspc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  // ------------------------------------------------------------------
  // storage and pointers
  // ------------------------------------------------------------------
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] rdPtr_q;
  logic [PTR_W:0] cnt_q;
  logic [PTR_W:0] cnt_d;
  logic headValid_q;
  logic [WIDTH-1:0] headData_q;

  wire push = inValid && inReady;
  wire pop = (cnt_q != '0) && (!headValid_q || outReady);
  wire [PTR_W-1:0] wrNext = (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + 1'b1;
  wire [PTR_W-1:0] rdNext = (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + 1'b1;

  assign inReady = (cnt_q != FULL_CNT);
  assign outValid = headValid_q;
  assign outData = headData_q;
  assign cnt_d = cnt_q + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};

  // ------------------------------------------------------------------
  // pointer, count and head registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q <= '0;
      headValid_q <= 1'b0;
      headData_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      if (push) begin
        wrPtr_q <= wrNext;
      end
      if (pop) begin
        rdPtr_q <= rdNext;
        headValid_q <= 1'b1;
        headData_q <= mem[rdPtr_q];
      end else if (outReady) begin
        headValid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

endmodule

//--- verilog/pspc_pkg.sv
// shared constants and types for the pipelined sram pin control block
package pspc_pkg;

  // ------------------------------------------------------------------
  // geometry defaults
  // ------------------------------------------------------------------
  localparam int LANE_W = 8;
  localparam int LANES = 4;
  localparam int ADDR_W = 4;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 32;

  // ------------------------------------------------------------------
  // reset values and burst step
  // ------------------------------------------------------------------
  localparam logic RST_MODE = 1'b1;
  localparam logic RST_DRIVE = 1'b0;
  localparam logic [BURST_W-1:0] RST_BURST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  // ------------------------------------------------------------------
  // data phase state
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } pspc_phase_e;

  // ------------------------------------------------------------------
  // captured write record handed to the fifo
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] laneWrite;
    logic [LANES-1:0] parity;
    logic [LANES*LANE_W-1:0] data;
  } pspc_capture_s;

endpackage

//--- verilog/pspc_sram_pins.sv
// What this block does
// - act only on edges with qualify low
// - qualify high freezes access state and pin outputs
// - selected only for low, high, low enables
// - output enable high tristates pins immediately
// - no drive on write data, deselect, reemergence
// - capture input pins on qualified rising edge while dataOe is low
// - read data follows address by one edge
// - parity bits follow their byte lane selects
// - strap high interleaved, low linear bursts
// - write request low writes, high reads
// - advance steps burst, low loads address
// - lane selects gate each byte and parity
`timescale 1ns/1ps
module pspc_sram_pins #(
  parameter int LANE_W = pspc_pkg::LANE_W,
  parameter int LANES = pspc_pkg::LANES,
  parameter int ADDR_W = pspc_pkg::ADDR_W,
  parameter int FIFO_DEPTH = pspc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clock_qualify_n,
  input wire logic select_low_a_n,
  input wire logic select_high,
  input wire logic select_low_b_n,
  input wire logic writeRequest_n,
  input wire logic advance_or_load,
  input wire logic [LANES-1:0] lane_write_select_n,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire logic outputEnable_n,
  input wire logic burstModeStrap,
  input wire logic [LANES*LANE_W-1:0] dataIn,
  output logic [LANES*LANE_W-1:0] dataOut,
  output logic dataOe,
  input wire logic [LANES-1:0] parity_lines_in,
  output logic [LANES-1:0] parity_lines_out,
  output logic parityOe,
  output logic captureValid,
  input wire logic captureReady,
  output pspc_pkg::pspc_capture_s captureData
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  localparam int WORD_W = LANES * (LANE_W + 1);
  localparam int DATA_W = LANES * LANE_W;
  localparam int BW = pspc_pkg::BURST_W;

  logic [WORD_W-1:0] core [2**ADDR_W];
  logic [ADDR_W-1:0] baseAddr_q;
  logic [ADDR_W-1:0] accessAddr_q;
  logic [ADDR_W-1:0] accessAddr_d;
  logic [BW-1:0] burstCnt_q;
  logic [BW-1:0] burstCnt_d;
  logic burstActive_q;
  logic burstWrite_q;
  logic [LANES-1:0] laneSel_q;
  pspc_pkg::pspc_phase_e phase_q;
  pspc_pkg::pspc_phase_e phase_d;
  logic [DATA_W-1:0] readData_q;
  logic [LANES-1:0] readParity_q;
  logic drive_q;
  logic [DATA_W-1:0] captured_q;
  logic [LANES-1:0] capturedPar_q;
  logic modeS1_q;
  logic modeS2_q;
  logic modeS3_q;
  logic mode_q;
  logic fifoInReady;
  logic [WORD_W-1:0] mergedWord;
  pspc_pkg::pspc_capture_s pushRec;

  // ------------------------------------------------------------------
  // qualification and decode
  // ------------------------------------------------------------------
  wire writePhase = (phase_q == pspc_pkg::ST_WRITE);
  wire readPhase = (phase_q == pspc_pkg::ST_READ);
  wire fifoStall = writePhase && !fifoInReady;
  wire qualified = !clock_qualify_n && !fifoStall;
  wire selectedNow = !select_low_a_n && select_high && !select_low_b_n;
  wire loadCycle = !advance_or_load;
  wire loadSelected = loadCycle && selectedNow;
  wire isWriteReq = !writeRequest_n;
  wire [BW-1:0] nextCnt = burstCnt_q + pspc_pkg::BURST_STEP;
  wire [BW-1:0] lowInterleave = baseAddr_q[BW-1:0] ^ nextCnt;
  wire [BW-1:0] lowLinear = baseAddr_q[BW-1:0] + nextCnt;
  wire [BW-1:0] lowNext = mode_q ? lowInterleave : lowLinear;
  wire [ADDR_W-1:0] advAddr = {baseAddr_q[ADDR_W-1:BW], lowNext};
  wire [WORD_W-1:0] curWord = core[accessAddr_q];
  wire doWrite = qualified && writePhase;

  // ------------------------------------------------------------------
  // next access state
  // ------------------------------------------------------------------
  always_comb begin
    accessAddr_d = accessAddr_q;
    burstCnt_d = burstCnt_q;
    phase_d = pspc_pkg::ST_IDLE;
    if (loadCycle) begin
      if (selectedNow) begin
        accessAddr_d = addrIn;
        burstCnt_d = pspc_pkg::RST_BURST;
        phase_d = isWriteReq ? pspc_pkg::ST_WRITE : pspc_pkg::ST_READ;
      end
    end else if (burstActive_q) begin
      accessAddr_d = advAddr;
      burstCnt_d = nextCnt;
      phase_d = burstWrite_q ? pspc_pkg::ST_WRITE : pspc_pkg::ST_READ;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baseAddr_q <= '0;
      accessAddr_q <= '0;
      burstCnt_q <= pspc_pkg::RST_BURST;
      burstActive_q <= 1'b0;
      burstWrite_q <= 1'b0;
      laneSel_q <= '0;
      phase_q <= pspc_pkg::ST_IDLE;
    end else if (qualified) begin
      accessAddr_q <= accessAddr_d;
      burstCnt_q <= burstCnt_d;
      phase_q <= phase_d;
      laneSel_q <= ~lane_write_select_n;
      if (loadCycle) begin
        baseAddr_q <= addrIn;
        burstActive_q <= selectedNow;
        burstWrite_q <= loadSelected && isWriteReq;
      end
    end
  end

  // ------------------------------------------------------------------
  // byte lane merge
  // ------------------------------------------------------------------
  genvar ln;
  generate
    for (ln = 0; ln < LANES; ln++) begin : g_lane
      localparam int DB = ln * LANE_W;
      localparam int PB = DATA_W + ln;
      assign mergedWord[DB +: LANE_W] = laneSel_q[ln] ? dataIn[DB +: LANE_W] :
                                        curWord[DB +: LANE_W];
      assign mergedWord[PB] = laneSel_q[ln] ? parity_lines_in[ln] : curWord[PB];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (doWrite) begin
      core[accessAddr_q] <= mergedWord;
    end
  end

  // ------------------------------------------------------------------
  // output pipeline and input capture
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readData_q <= '0;
      readParity_q <= '0;
      drive_q <= pspc_pkg::RST_DRIVE;
      captured_q <= '0;
      capturedPar_q <= '0;
    end else if (qualified) begin
      drive_q <= readPhase;
      if (readPhase) begin
        readData_q <= curWord[DATA_W-1:0];
        readParity_q <= curWord[WORD_W-1:DATA_W];
      end
      if (!dataOe) begin
        captured_q <= dataIn;
        capturedPar_q <= parity_lines_in;
      end
    end
  end

  assign dataOut = readData_q;
  assign parity_lines_out = readParity_q;
  assign dataOe = drive_q && !outputEnable_n;
  assign parityOe = drive_q && !outputEnable_n;

  // ------------------------------------------------------------------
  // burst order strap
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeS1_q <= pspc_pkg::RST_MODE;
      modeS2_q <= pspc_pkg::RST_MODE;
      modeS3_q <= pspc_pkg::RST_MODE;
      mode_q <= pspc_pkg::RST_MODE;
    end else begin
      modeS1_q <= burstModeStrap;
      modeS2_q <= modeS1_q;
      modeS3_q <= modeS2_q;
      if (modeS2_q == modeS3_q) begin
        mode_q <= modeS2_q;
      end
    end
  end

  // ------------------------------------------------------------------
  // captured write stream
  // ------------------------------------------------------------------
  assign pushRec.addr = accessAddr_q;
  assign pushRec.laneWrite = laneSel_q;
  assign pushRec.parity = parity_lines_in;
  assign pushRec.data = dataIn;

  pspc_fifo #(
    .WIDTH($bits(pspc_pkg::pspc_capture_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(doWrite),
    .inReady(fifoInReady),
    .inData(pushRec),
    .outValid(captureValid),
    .outReady(captureReady),
    .outData(captureData)
  );

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_HOLD: assert property (@(posedge clk) disable iff (rst)
    clock_qualify_n |=> $stable(readData_q) && $stable(drive_q) && $stable(phase_q))
    else $error("state moved while clock not qualified");

  AST_NOACT: assert property (@(posedge clk) disable iff (rst)
    clock_qualify_n |=> $stable(accessAddr_q) && $stable(burstCnt_q))
    else $error("address moved on unqualified edge");

  AST_DESEL: assert property (@(posedge clk) disable iff (rst)
    qualified && loadCycle && !selectedNow
    |=> phase_q == pspc_pkg::ST_IDLE ##1 (!drive_q || !$past(qualified)))
    else $error("deselect did not idle the data phase");

  AST_OE: assert property (@(posedge clk) disable iff (rst)
    outputEnable_n |-> !dataOe && !parityOe)
    else $error("pins driven while output enable high");

  AST_WRMASK: assert property (@(posedge clk) disable iff (rst)
    qualified && loadSelected && isWriteReq ##1 qualified |=> !drive_q && !dataOe)
    else $error("drive during write data phase");

  AST_RDLAT: assert property (@(posedge clk) disable iff (rst)
    qualified && loadSelected && !isWriteReq ##1 qualified |=> drive_q)
    else $error("read data not driven one edge after address");

  AST_LOAD: assert property (@(posedge clk) disable iff (rst)
    qualified && loadSelected |=> accessAddr_q == $past(addrIn))
    else $error("load did not take the address");

  AST_WRTYPE: assert property (@(posedge clk) disable iff (rst)
    qualified && loadSelected |=> (phase_q == pspc_pkg::ST_WRITE) == $past(isWriteReq))
    else $error("access type does not match write request");

  AST_LINEAR: assert property (@(posedge clk) disable iff (rst)
    qualified && !loadCycle && burstActive_q && !mode_q && $stable(mode_q)
    |=> accessAddr_q[BW-1:0] == $past(accessAddr_q[BW-1:0]) + pspc_pkg::BURST_STEP)
    else $error("linear burst did not step by one");

  COV_READ: cover property (@(posedge clk) disable iff (rst)
    qualified && loadSelected && !isWriteReq ##1 qualified ##1 dataOe);
  COV_BURST: cover property (@(posedge clk) disable iff (rst)
    qualified && loadSelected ##1 (qualified && !loadCycle) [*3]);
  COV_STALL: cover property (@(posedge clk) disable iff (rst)
    writePhase && !fifoInReady);
  COV_SUSPEND: cover property (@(posedge clk) disable iff (rst)
    drive_q && clock_qualify_n [*2]);

endmodule
